// ### design/nib_pkg.sv
// Package: constants and state type for the nibble controller bring-up model
`default_nettype none
package nib_pkg;
    // Clock period of ref_clk, in ns
    localparam int CLK_PERIOD_NS = 8;
    // Initial self-calibration run time, a least time
    localparam int CAL_TIME_NS = 1000;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Latency from compensation enable to active tracking, a least time
    localparam int TRACK_TIME_NS = 64;
    localparam int TRACK_CYCLES = (TRACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Counter width and synchroniser layout
    localparam int CNT_W = 8;
    localparam int SYNC_W = 3;
    localparam int SYNC_RESET_BIT = 0;
    localparam int SYNC_FASTCLK_BIT = 1;
    localparam int SYNC_VTCOMP_BIT = 2;
    // Controller reset bit starts asserted so the state machine stays in hold until the filter sees the real level
    localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 3'h1;
    // Controller states
    typedef enum logic [2:0] {
        NIB_HOLD,
        NIB_WAIT_CLK,
        NIB_CALIBRATE,
        NIB_NO_CAL,
        NIB_CAL_DONE,
        NIB_TRACK_START,
        NIB_TRACKING
    } nib_state_t;
endpackage
`default_nettype wire

// ### design/nib_sync_if.sv
// Interface: synchronised control levels between the input stage and the controller
`default_nettype none
interface nib_sync_if;
    logic ctrl_reset;
    logic fast_clk_on;
    logic vt_comp_enable;
    modport sync_side (output ctrl_reset, output fast_clk_on, output vt_comp_enable);
    modport ctrl_side (input ctrl_reset, input fast_clk_on, input vt_comp_enable);
endinterface
`default_nettype wire

// ### design/nib_in_sync.sv
// Input stage: three-flop synchronisers with agreement filter for sequencer levels
`default_nettype none
module nib_in_sync
    import nib_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Raw levels from the sequencer
    input wire logic ctrl_reset_raw,
    input wire logic fast_clk_on_raw,
    input wire logic vt_comp_enable_raw,
    // Filtered levels
    nib_sync_if.sync_side sync
);
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
    logic [SYNC_W-1:0] stage3;
    logic [SYNC_W-1:0] level;

    // Gather the raw pins into one vector
    assign raw_in[SYNC_RESET_BIT] = ctrl_reset_raw;
    assign raw_in[SYNC_FASTCLK_BIT] = fast_clk_on_raw;
    assign raw_in[SYNC_VTCOMP_BIT] = vt_comp_enable_raw;

    // Per-bit chain; a change counts only once stages two and three agree
    for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                stage1[i] <= SYNC_RESET_VAL[i];
                stage2[i] <= SYNC_RESET_VAL[i];
                stage3[i] <= SYNC_RESET_VAL[i];
                level[i] <= SYNC_RESET_VAL[i];
            end else if (clk_en) begin
                stage1[i] <= raw_in[i];
                stage2[i] <= stage1[i];
                stage3[i] <= stage2[i];
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end

    assign sync.ctrl_reset = level[SYNC_RESET_BIT];
    assign sync.fast_clk_on = level[SYNC_FASTCLK_BIT];
    assign sync.vt_comp_enable = level[SYNC_VTCOMP_BIT];
endmodule
`default_nettype wire

// ### design/nib_ctrl.sv
// Nibble controller calibration and voltage/temperature tracking bring-up model
`default_nettype none
module nib_ctrl
    import nib_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Static options
    input wire logic self_cal_enable,
    input wire logic input_delay_tracking,
    input wire logic output_delay_tracking,
    input wire logic quarter_delay_tracking,
    // Sequencer levels, asynchronous to ref_clk
    input wire logic ctrl_reset,
    input wire logic fast_clk_on,
    input wire logic vt_comp_enable,
    // Status
    output logic delay_cal_done,
    output logic vt_tracking_ready,
    output logic cal_busy,
    output logic idly_comp_active,
    output logic odly_comp_active,
    output logic qdly_comp_active
);
    import nib_pkg::*;

    nib_sync_if sync_bus ();
    nib_state_t state;
    nib_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic cal_last;
    logic track_last;
    logic tracking_next;

    // Filter the sequencer levels into this clock domain
    nib_in_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .ctrl_reset_raw(ctrl_reset),
        .fast_clk_on_raw(fast_clk_on),
        .vt_comp_enable_raw(vt_comp_enable),
        .sync(sync_bus)
    );

    // Terminal counts of the two timed phases
    assign cal_last = (cnt == CNT_W'(CAL_CYCLES - 1));
    assign track_last = (cnt == CNT_W'(TRACK_CYCLES - 1));

    // Next state; controller reset overrides everything
    always_comb begin
        next_state = state;
        next_cnt = '0;
        if (sync_bus.ctrl_reset) begin
            next_state = NIB_HOLD;
        end else begin
            unique case (state)
                NIB_HOLD: begin
                    next_state = NIB_WAIT_CLK;
                end
                NIB_WAIT_CLK: begin
                    // Calibration needs the fast clock, which the sequencer gates until resets settle
                    if (sync_bus.fast_clk_on) begin
                        next_state = self_cal_enable ? NIB_CALIBRATE : NIB_NO_CAL;
                    end
                end
                NIB_CALIBRATE: begin
                    next_cnt = cnt + CNT_W'(1);
                    if (cal_last) begin
                        next_state = NIB_CAL_DONE;
                        next_cnt = '0;
                    end
                end
                NIB_NO_CAL: begin
                    next_state = NIB_NO_CAL;
                end
                NIB_CAL_DONE: begin
                    // Controller enable stays low until cal done is seen
                    if (sync_bus.vt_comp_enable) begin
                        next_state = NIB_TRACK_START;
                    end
                end
                NIB_TRACK_START: begin
                    next_cnt = cnt + CNT_W'(1);
                    if (!sync_bus.vt_comp_enable) begin
                        next_state = NIB_CAL_DONE;
                        next_cnt = '0;
                    end else if (track_last) begin
                        next_state = NIB_TRACKING;
                        next_cnt = '0;
                    end
                end
                NIB_TRACKING: begin
                    // Dropping the enable pauses tracking so delays can be reprogrammed
                    if (!sync_bus.vt_comp_enable) begin
                        next_state = NIB_CAL_DONE;
                    end
                end
            endcase
        end
    end

    assign tracking_next = (next_state == NIB_TRACKING);

    // State and counter registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= NIB_HOLD;
            cnt <= '0;
        end else if (clk_en) begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Registered status outputs; tracking flags gated by their options
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            delay_cal_done <= 1'b0;
            vt_tracking_ready <= 1'b0;
            cal_busy <= 1'b0;
            idly_comp_active <= 1'b0;
            odly_comp_active <= 1'b0;
            qdly_comp_active <= 1'b0;
        end else if (clk_en) begin
            delay_cal_done <= (next_state == NIB_CAL_DONE) || (next_state == NIB_TRACK_START)
                || tracking_next;
            cal_busy <= (next_state == NIB_CALIBRATE);
            vt_tracking_ready <= tracking_next;
            idly_comp_active <= tracking_next && input_delay_tracking;
            odly_comp_active <= tracking_next && output_delay_tracking;
            qdly_comp_active <= tracking_next && quarter_delay_tracking;
        end
    end

    // Checks on the controller's own outputs
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_no_cal_disabled: assert property (!self_cal_enable && state == NIB_WAIT_CLK |=> !cal_busy)
        else $error("calibration started with self calibration disabled");
    a_cal_starts: assert property (self_cal_enable && clk_en && state == NIB_WAIT_CLK && sync_bus.fast_clk_on
        && !sync_bus.ctrl_reset |=> cal_busy && state == NIB_CALIBRATE)
        else $error("calibration did not start after reset release");
    a_cal_done_time: assert property (clk_en && state == NIB_CALIBRATE && cal_last && !sync_bus.ctrl_reset
        |=> delay_cal_done && !cal_busy)
        else $error("delay_cal_done not raised at end of calibration");
    a_done_needs_cal: assert property ($rose(delay_cal_done) |-> $past(state) == NIB_CALIBRATE)
        else $error("delay_cal_done rose without calibration");
    a_ready_after_done: assert property (vt_tracking_ready |-> delay_cal_done)
        else $error("tracking ready without calibration done");
    a_ready_latency: assert property ($rose(vt_tracking_ready) |-> $past(state == NIB_TRACK_START)
        && $past(sync_bus.vt_comp_enable))
        else $error("tracking ready without enabled start phase");
    a_idly_option: assert property (idly_comp_active |-> vt_tracking_ready && $past(input_delay_tracking))
        else $error("input delay compensation active without option");
    a_odly_option: assert property (odly_comp_active |-> vt_tracking_ready && $past(output_delay_tracking))
        else $error("output delay compensation active without option");
    a_qdly_option: assert property (clk_en && tracking_next && quarter_delay_tracking
        |=> qdly_comp_active)
        else $error("quarter delay compensation not active while tracking");
    a_reset_clears: assert property (clk_en && sync_bus.ctrl_reset |=> !delay_cal_done && !vt_tracking_ready)
        else $error("status not cleared by controller reset");

    c_full_bringup: cover property ($rose(vt_tracking_ready));
    c_no_cal_path: cover property (state == NIB_NO_CAL);
    c_track_pause: cover property ($fell(vt_tracking_ready) && delay_cal_done);
endmodule
`default_nettype wire

// ### bench/nib_seq_model.sv
// Behavioural fabric sequencer driving the controller's bring-up levels
`default_nettype none
module nib_seq_model (
    // Clock, reset, run request, test options
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic early_vtc,
    input wire logic rx_used,
    // Controller status
    input wire logic delay_cal_done,
    input wire logic vt_tracking_ready,
    // Bring-up levels
    output logic ctrl_reset,
    output logic fast_clk_on,
    output logic vt_comp_enable,
    output logic [3:0] tx_byte_gate,
    output logic [3:0] phy_read_enable,
    output logic strobe_run
);
    logic [7:0] cnt;
    logic [1:0] cal_sync;
    logic [1:0] rdy_sync;

    // Step counter; lock is taken as reached at step 10, fast clock 65 steps after release
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !go) begin
            cnt <= 8'h00;
            ctrl_reset <= 1'b1;
            fast_clk_on <= 1'b0;
            vt_comp_enable <= 1'b0;
            cal_sync <= 2'h0;
            rdy_sync <= 2'h0;
            tx_byte_gate <= 4'h0;
            phy_read_enable <= 4'h0;
            strobe_run <= 1'b0;
        end else begin
            cnt <= cnt + {7'h00, cnt != 8'hff};
            if (cnt == 8'h0a) ctrl_reset <= 1'b0;
            // Fast clock level also stands for the serial receive sampling clock
            if (cnt == 8'h4b) fast_clk_on <= 1'b1;
            cal_sync <= {cal_sync[0], delay_cal_done};
            // Early raise only when a test asks for the misordered case
            if (cal_sync[1] || early_vtc) vt_comp_enable <= 1'b1;
            rdy_sync <= {rdy_sync[0], vt_tracking_ready};
            tx_byte_gate <= {4{rdy_sync[1]}};
            // Read enables only where receive lanes exist; transmit-only keeps them low
            phy_read_enable <= {4{rdy_sync[1] && rx_used}};
            // Strobes stay stopped until tracking is ready, so no bit-slip is modelled
            strobe_run <= rdy_sync[1];
        end
    end
endmodule
`default_nettype wire

// ### bench/nib_ctrl_tb_top.sv
// Testbench: bring-up sequences of the nibble controller against the sequencer model
`default_nettype none
module nib_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nib_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic self_cal_enable = 1'b1;
    logic input_delay_tracking = 1'b1;
    logic output_delay_tracking = 1'b1;
    logic quarter_delay_tracking = 1'b1;
    logic go = 1'b0;
    logic early_vtc = 1'b0;
    logic rx_used = 1'b0;
    wire logic strobe_run;
    wire logic [3:0] phy_read_enable;
    wire logic ctrl_reset, fast_clk_on, vt_comp_enable;
    wire logic delay_cal_done, vt_tracking_ready, cal_busy, ia, oa, qa;
    wire logic [3:0] tx_byte_gate;
    int bad_count = 0;
    int num_checks = 0;

    nib_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .self_cal_enable(self_cal_enable),
        .input_delay_tracking(input_delay_tracking), .output_delay_tracking(output_delay_tracking),
        .quarter_delay_tracking(quarter_delay_tracking), .ctrl_reset(ctrl_reset), .fast_clk_on(fast_clk_on),
        .vt_comp_enable(vt_comp_enable), .delay_cal_done(delay_cal_done), .vt_tracking_ready(vt_tracking_ready),
        .cal_busy(cal_busy), .idly_comp_active(ia), .odly_comp_active(oa), .qdly_comp_active(qa));
    nib_seq_model i_seq (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .early_vtc(early_vtc), .rx_used(rx_used),
        .delay_cal_done(delay_cal_done), .vt_tracking_ready(vt_tracking_ready), .ctrl_reset(ctrl_reset),
        .fast_clk_on(fast_clk_on), .vt_comp_enable(vt_comp_enable), .tx_byte_gate(tx_byte_gate),
        .phy_read_enable(phy_read_enable), .strobe_run(strobe_run));

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task tick;
        @(posedge ref_clk);
        #1;
    endtask

    // One full bring-up; opts = {self cal, input, output, quarter tracking}
    task bring_up(input logic [3:0] opts, input logic early);
        int n;
        int b;
        int r;
        b = 0;
        r = 0;
        @(posedge ref_clk);
        {self_cal_enable, input_delay_tracking, output_delay_tracking, quarter_delay_tracking} <= opts;
        early_vtc <= early;
        // Receive lanes present when input delays are tracked
        rx_used <= opts[2];
        go <= 1'b1;
        for (n = 0; n < 100 && fast_clk_on !== 1'b1; n++) tick();
        // Sampled from the edge that raised the fast clock level
        for (n = 0; n < 200 && delay_cal_done !== 1'b1; n++) begin
            tick();
            b += int'(cal_busy === 1'b1);
            r += int'(vt_tracking_ready === 1'b1);
        end
        check(8'(delay_cal_done), 8'(opts[3]));
        check(8'(b), opts[3] ? 8'(CAL_CYCLES) : 8'h00);
        if (opts[3]) check(8'(n), 8'(5 + CAL_CYCLES));
        check(8'(r), 8'h00);
        if (opts[3]) begin
            for (n = 0; n < 40 && vt_tracking_ready !== 1'b1; n++) tick();
            if (!early) check(8'(n), 8'(8 + TRACK_CYCLES));
            check(8'(vt_tracking_ready), 8'h01);
            check(8'({ia, oa, qa}), 8'(opts[2:0]));
            check(8'(tx_byte_gate), 8'h00);
            check(8'({strobe_run, phy_read_enable}), 8'h00);
            repeat (3) tick();
            check(8'(tx_byte_gate), 8'h0f);
            check(8'({strobe_run, phy_read_enable}), 8'({1'b1, {4{opts[2]}}}));
        end
        @(posedge ref_clk);
        go <= 1'b0;
        // Early case also freezes the controller while its sequencer drops away
        if (early) begin
            clk_en <= 1'b0;
            repeat (8) tick();
            check(8'({delay_cal_done, vt_tracking_ready, cal_busy, ia, oa, qa}), 8'({3'b110, opts[2:0]}));
            @(posedge ref_clk);
            clk_en <= 1'b1;
        end
        repeat (8) tick();
        check(8'({delay_cal_done, vt_tracking_ready, cal_busy, ia, oa, qa}), 8'h00);
        $display("test done opts %b early %b", opts, early);
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        tick();
        check(8'({delay_cal_done, vt_tracking_ready, cal_busy, ia, oa, qa}), 8'h00);
        bring_up(4'hf, 1'b0);
        bring_up(4'ha, 1'b0);
        bring_up(4'hd, 1'b0);
        bring_up(4'h7, 1'b0);
        bring_up(4'hf, 1'b1);
        conclude();
    end

    // Watchdog, about four times the expected run
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
